/* File: verilog/config_decode_pkg.sv */
`default_nettype none
package config_decode_pkg;

   // ----------------------------------------------------------------
   // configuration register indexes
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CFG_BASE_LOW = 8'h12;
   localparam logic [7:0] IDX_CFG_BASE_HIGH = 8'h13;
   localparam logic [7:0] IDX_PAR_BASE = 8'h23;
   localparam logic [7:0] IDX_SER1_BASE = 8'h24;
   localparam logic [7:0] IDX_SER2_BASE = 8'h25;
   localparam logic [7:0] IDX_IR_BASE = 8'h2B;
   localparam logic [7:0] IDX_RT_BASE = 8'h30;
   localparam logic [7:0] IDX_UPPER_POL = 8'h38;
   localparam logic [7:0] IDX_BUF_TYPE = 8'h39;

   // ----------------------------------------------------------------
   // reset values and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] UPPER_POL_RESET = 8'h00;
   localparam logic [7:0] BUF_TYPE_RESET = 8'h80;
   localparam logic [7:0] DEV_BASE_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [15:0] CFG_BASE_STRAP_LOW = 16'h002E;
   localparam logic [15:0] CFG_BASE_STRAP_HIGH = 16'h004E;
   localparam logic [7:0] ENTER_KEY_DEFAULT = 8'h55;
   localparam logic [7:0] EXIT_KEY_DEFAULT = 8'hAA;
   localparam int BUF_PME_BIT = 7;
   localparam int BUF_TRIO_MSB = 2;
   localparam int PAR_IRQ_EN_BIT = 4;
   localparam int SER_GATE_BIT = 2;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // parallel extended-control mode field
   localparam logic [2:0] ECR_MODE_FIFO = 3'h2;
   localparam logic [2:0] ECR_MODE_ECP = 3'h3;
   localparam logic [2:0] ECR_MODE_TEST = 3'h6;

   // ----------------------------------------------------------------
   // decode windows: 0 parallel, 1 parallel +400h, 2 serial one,
   // 3 serial two, 4 infrared, 5 runtime block
   // ----------------------------------------------------------------
   localparam int NUM_WIN = 6;
   localparam int NUM_BASE = 5;
   localparam int WIN_PAR = 0;
   localparam int WIN_PAR_EXT = 1;
   localparam int WIN_SER1 = 2;
   localparam int WIN_SER2 = 3;
   localparam int WIN_IR = 4;
   localparam int WIN_RT = 5;
   localparam int WIN_BASE_IDX [NUM_WIN] = '{0, 0, 1, 2, 3, 4};
   localparam int WIN_SHIFT [NUM_WIN] = '{2, 2, 2, 2, 3, 4};
   localparam int WIN_BITS [NUM_WIN] = '{3, 2, 3, 3, 3, 4};
   localparam int WIN_ALIGN [NUM_WIN] = '{2, 2, 3, 3, 3, 4};
   localparam logic [15:0] WIN_ADD [NUM_WIN] =
      '{16'h0000, 16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] WIN_LO [NUM_WIN] =
      '{16'h0100, 16'h0500, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
   localparam logic [15:0] WIN_HI [NUM_WIN] =
      '{16'h03FC, 16'h07FC, 16'h03F8, 16'h03F8, 16'h07F8, 16'h0FF0};
   localparam logic [7:0] BASE_INDEX [NUM_BASE] =
      '{IDX_PAR_BASE, IDX_SER1_BASE, IDX_SER2_BASE, IDX_IR_BASE, IDX_RT_BASE};

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_CONFIG = 2'b10
   } cfg_state_type;

endpackage
`default_nettype wire

/* File: verilog/base_window_decode.sv */
`default_nettype none
module base_window_decode #(
   parameter int WIN_BITS = 3,
   parameter int ALIGN_BITS = 3,
   parameter logic [15:0] LO = 16'h0100,
   parameter logic [15:0] HI = 16'h03F8
) (
   input wire logic [15:0] base_addr,
   input wire logic [15:0] addr,
   input wire logic narrow,
   output logic valid,
   output logic hit
);

   localparam logic [15:0] WIN_MASK = 16'hFFFF << WIN_BITS;
   localparam logic [15:0] NARROW_MASK = 16'hFFFF << (WIN_BITS - 1);
   localparam logic [15:0] ALIGN_MASK = ~(16'hFFFF << ALIGN_BITS);

   if (WIN_BITS < 1 || WIN_BITS > 12 || ALIGN_BITS > 12)
      $error("window or alignment size out of range");

   // only bits above the window size are compared, or above half of it when narrow is set
   always_comb
   begin
      valid = (base_addr >= LO) && (base_addr <= HI) && ((base_addr & ALIGN_MASK) == 16'h0000);
      hit = valid
            && (((addr ^ base_addr) & (narrow ? NARROW_MASK : WIN_MASK)) == 16'h0000);
   end

endmodule
`default_nettype wire

/* File: verilog/gpio_pad_ctrl.sv */
`default_nettype none
module gpio_pad_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] polarity,
   input wire logic [7:0] buffer_type,
   input wire logic [7:0] upper_out_data,
   input wire logic [7:0] upper_dir,
   input wire logic [7:0] upper_pin_sync,
   input wire logic [2:0] trio_out_data,
   input wire logic [2:0] trio_drive,
   input wire logic power_event_assert,
   output logic [7:0] upper_o,
   output logic [7:0] upper_oe,
   output logic [7:0] upper_in_value,
   output logic [2:0] trio_o,
   output logic [2:0] trio_oe,
   output logic power_event_o,
   output logic power_event_oe
);

   logic [7:0] upper_o_next;
   logic [7:0] upper_in_next;
   logic [2:0] trio_o_next;
   logic [2:0] trio_oe_next;
   logic pme_o_next;
   logic pme_oe_next;

   // ----------------------------------------------------------------
   // pad drive
   // ----------------------------------------------------------------
   always_comb
   begin
      upper_o_next = upper_out_data ^ polarity;
      upper_in_next = upper_pin_sync ^ polarity;
      // open drain only pulls low; bits 3..6 are never looked at
      for (int i = 0; i <= config_decode_pkg::BUF_TRIO_MSB; i++)
      begin
         trio_o_next[i] = buffer_type[i] ? 1'b0 : trio_out_data[i];
         trio_oe_next[i] = trio_drive[i] & (~buffer_type[i] | ~trio_out_data[i]);
      end
      // pin is active low
      pme_o_next = ~power_event_assert & ~buffer_type[config_decode_pkg::BUF_PME_BIT];
      pme_oe_next = ~buffer_type[config_decode_pkg::BUF_PME_BIT] | power_event_assert;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         upper_o <= 8'h00;
         upper_oe <= 8'h00;
         upper_in_value <= 8'h00;
         trio_o <= 3'h0;
         trio_oe <= 3'h0;
         power_event_o <= 1'b0;
         power_event_oe <= 1'b0;
      end
      else
      begin
         upper_o <= upper_o_next;
         upper_oe <= upper_dir;
         upper_in_value <= upper_in_next;
         trio_o <= trio_o_next;
         trio_oe <= trio_oe_next;
         power_event_o <= pme_o_next;
         power_event_oe <= pme_oe_next;
      end
   end

   property p_upper_polarity;
      @(posedge clk) disable iff (!resetn)
      1'b1 |=> upper_o == $past(upper_out_data ^ polarity);
   endproperty
   a_upper_polarity: assert property (p_upper_polarity)
      else $error("upper bank polarity wrong");

   property p_pme_open_drain;
      @(posedge clk) disable iff (!resetn)
      buffer_type[7] && power_event_assert |=> !power_event_o && power_event_oe;
   endproperty
   a_pme_open_drain: assert property (p_pme_open_drain)
      else $error("event pin not pulled low");

endmodule
`default_nettype wire

/* File: verilog/config_gpio_base_decode.sv */
`default_nettype none
module config_gpio_base_decode #(
   parameter logic [7:0] ENTER_KEY = config_decode_pkg::ENTER_KEY_DEFAULT,
   parameter logic [7:0] EXIT_KEY = config_decode_pkg::EXIT_KEY_DEFAULT
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rack,
   output logic [5:0] dev_sel,
   output logic [3:0] dev_offset,
   output logic dev_wr,
   output logic dev_rd,
   input wire logic config_port_strap,
   input wire logic [3:0] dev_active,
   input wire logic par_irq_req,
   input wire logic par_dma_req,
   input wire logic [7:0] par_control,
   input wire logic [2:0] par_ecr_mode,
   input wire logic parallel_dma_enable,
   input wire logic [1:0] ser_irq_req,
   input wire logic [7:0] ser1_modem_control_reg,
   input wire logic [7:0] ser2_modem_control_reg,
   input wire logic ir_irq_req,
   input wire logic ir_dma_req,
   input wire logic ir_dma_enable,
   output logic par_irq,
   output logic par_dma,
   output logic [1:0] ser_irq,
   output logic ir_irq,
   output logic ir_dma,
   input wire logic [7:0] upper_gpio_out_data,
   input wire logic [7:0] upper_gpio_dir,
   input wire logic [7:0] upper_gpio_bank_in,
   output logic [7:0] upper_gpio_bank_o,
   output logic [7:0] upper_gpio_bank_oe,
   output logic [7:0] upper_gpio_value,
   input wire logic [2:0] low_gpio_trio_data,
   input wire logic [2:0] low_gpio_trio_drive,
   output logic [2:0] low_gpio_trio_o,
   output logic [2:0] low_gpio_trio_oe,
   input wire logic power_event_assert,
   output logic power_event_pin_o,
   output logic power_event_pin_oe
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   config_decode_pkg::cfg_state_type state_reg, state_next;
   logic [7:0] index_reg, index_next;
   logic [7:0] pol_reg, pol_next;
   logic [7:0] buf_reg, buf_next;
   logic [7:0] base_reg [config_decode_pkg::NUM_BASE];
   logic [7:0] base_next [config_decode_pkg::NUM_BASE];
   logic [15:0] cfg_base_reg, cfg_base_next;
   logic [1:0] settle_reg, settle_next;
   logic strap_done_reg, strap_done_next;
   logic [7:0] rdata_next;
   logic rack_next;
   logic [1:0] strap_sync_reg;
   logic [7:0] pin_meta_reg, pin_sync_reg;
   logic idx_hit, dat_hit, cfg_wr;
   logic [15:0] win_base [config_decode_pkg::NUM_WIN];
   logic [5:0] win_valid, win_hit, sel_next;
   logic par_narrow, par_irq_en;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         strap_sync_reg <= 2'h0;
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
      end
      else
      begin
         strap_sync_reg <= {strap_sync_reg[0], config_port_strap};
         pin_meta_reg <= upper_gpio_bank_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // configuration port
   // ----------------------------------------------------------------
   assign idx_hit = (io_addr == cfg_base_reg);
   assign dat_hit = (io_addr == 16'(cfg_base_reg + 16'h0001));
   assign cfg_wr = io_wr && dat_hit && (state_reg == config_decode_pkg::ST_CONFIG);

   always_comb
   begin
      state_next = state_reg;
      index_next = index_reg;
      pol_next = pol_reg;
      buf_next = buf_reg;
      base_next = base_reg;
      cfg_base_next = cfg_base_reg;
      settle_next = settle_reg;
      strap_done_next = strap_done_reg;
      rdata_next = 8'h00;
      rack_next = 1'b0;
      // strap is sampled only once its synchroniser has settled
      if (!strap_done_reg)
      begin
         if (settle_reg == config_decode_pkg::STRAP_SETTLE)
         begin
            cfg_base_next = strap_sync_reg[1] ? config_decode_pkg::CFG_BASE_STRAP_HIGH
                                              : config_decode_pkg::CFG_BASE_STRAP_LOW;
            strap_done_next = 1'b1;
         end
         else
            settle_next = 2'(settle_reg + 2'h1);
      end
      case (state_reg)
         config_decode_pkg::ST_RUN:
         begin
            if (io_wr && idx_hit && strap_done_reg && io_wdata == ENTER_KEY)
               state_next = config_decode_pkg::ST_CONFIG;
         end
         config_decode_pkg::ST_CONFIG:
         begin
            if (io_wr && idx_hit)
            begin
               if (io_wdata == EXIT_KEY)
                  state_next = config_decode_pkg::ST_RUN;
               else
                  index_next = io_wdata;
            end
            if (cfg_wr)
            begin
               case (index_reg)
                  config_decode_pkg::IDX_CFG_BASE_LOW: cfg_base_next[7:0] = io_wdata;
                  config_decode_pkg::IDX_CFG_BASE_HIGH: cfg_base_next[15:8] = io_wdata;
                  config_decode_pkg::IDX_UPPER_POL: pol_next = io_wdata;
                  config_decode_pkg::IDX_BUF_TYPE: buf_next = io_wdata;
                  default: ;
               endcase
               for (int b = 0; b < config_decode_pkg::NUM_BASE; b++)
                  if (index_reg == config_decode_pkg::BASE_INDEX[b])
                     base_next[b] = io_wdata;
            end
            if (io_rd && idx_hit)
            begin
               rdata_next = index_reg;
               rack_next = 1'b1;
            end
            else if (io_rd && dat_hit)
            begin
               rack_next = 1'b1;
               case (index_reg)
                  config_decode_pkg::IDX_CFG_BASE_LOW: rdata_next = cfg_base_reg[7:0];
                  config_decode_pkg::IDX_CFG_BASE_HIGH: rdata_next = cfg_base_reg[15:8];
                  config_decode_pkg::IDX_UPPER_POL: rdata_next = pol_reg;
                  config_decode_pkg::IDX_BUF_TYPE: rdata_next = buf_reg;
                  default: rdata_next = 8'h00;
               endcase
               for (int b = 0; b < config_decode_pkg::NUM_BASE; b++)
                  if (index_reg == config_decode_pkg::BASE_INDEX[b])
                     rdata_next = base_reg[b];
            end
         end
         default: state_next = config_decode_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= config_decode_pkg::ST_RUN;
         index_reg <= config_decode_pkg::INDEX_RESET;
         pol_reg <= config_decode_pkg::UPPER_POL_RESET;
         buf_reg <= config_decode_pkg::BUF_TYPE_RESET;
         for (int b = 0; b < config_decode_pkg::NUM_BASE; b++)
            base_reg[b] <= config_decode_pkg::DEV_BASE_RESET;
         cfg_base_reg <= config_decode_pkg::CFG_BASE_STRAP_LOW;
         settle_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         io_rdata <= 8'h00;
         io_rack <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         index_reg <= index_next;
         pol_reg <= pol_next;
         buf_reg <= buf_next;
         base_reg <= base_next;
         cfg_base_reg <= cfg_base_next;
         settle_reg <= settle_next;
         strap_done_reg <= strap_done_next;
         io_rdata <= rdata_next;
         io_rack <= rack_next;
      end
   end

   // ----------------------------------------------------------------
   // logical device windows
   // ----------------------------------------------------------------
   // a parallel base with address bit 2 set (4-byte but not 8-byte aligned) loses the enhanced-parallel offsets
   assign par_narrow = base_reg[0][0];

   for (genvar w = 0; w < config_decode_pkg::NUM_WIN; w++)
   begin : g_win
      assign win_base[w] = 16'(({8'h00, base_reg[config_decode_pkg::WIN_BASE_IDX[w]]}
                           << config_decode_pkg::WIN_SHIFT[w]) + config_decode_pkg::WIN_ADD[w]);
      base_window_decode #(
         .WIN_BITS(config_decode_pkg::WIN_BITS[w]),
         .ALIGN_BITS(config_decode_pkg::WIN_ALIGN[w]),
         .LO(config_decode_pkg::WIN_LO[w]),
         .HI(config_decode_pkg::WIN_HI[w])
      ) u_win (
         .base_addr(win_base[w]),
         .addr(io_addr),
         .narrow((w == config_decode_pkg::WIN_PAR) ? par_narrow : 1'b0),
         .valid(win_valid[w]),
         .hit(win_hit[w])
      );
   end

   always_comb
   begin
      sel_next = win_hit;
      sel_next[0] = win_hit[0] && !(par_narrow && io_addr[1:0] == 2'h3);
      sel_next[1] = win_hit[1] && io_addr[1:0] != 2'h3;
      if (!(io_wr || io_rd))
         sel_next = 6'h00;
   end

   // ----------------------------------------------------------------
   // irq and dma gating
   // ----------------------------------------------------------------
   always_comb
   begin
      case (par_ecr_mode)
         config_decode_pkg::ECR_MODE_FIFO,
         config_decode_pkg::ECR_MODE_ECP,
         config_decode_pkg::ECR_MODE_TEST: par_irq_en = 1'b1;
         default: par_irq_en = par_control[config_decode_pkg::PAR_IRQ_EN_BIT];
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dev_sel <= 6'h00;
         dev_offset <= 4'h0;
         dev_wr <= 1'b0;
         dev_rd <= 1'b0;
         par_irq <= 1'b0;
         par_dma <= 1'b0;
         ser_irq <= 2'h0;
         ir_irq <= 1'b0;
         ir_dma <= 1'b0;
      end
      else
      begin
         dev_sel <= sel_next;
         dev_offset <= io_addr[3:0];
         dev_wr <= io_wr;
         dev_rd <= io_rd;
         par_irq <= par_irq_req && par_irq_en && dev_active[0] && win_valid[0];
         par_dma <= par_dma_req && parallel_dma_enable && dev_active[0] && win_valid[0];
         ser_irq[0] <= ser_irq_req[0] && ser1_modem_control_reg[config_decode_pkg::SER_GATE_BIT]
                       && dev_active[1] && win_valid[2];
         ser_irq[1] <= ser_irq_req[1] && ser2_modem_control_reg[config_decode_pkg::SER_GATE_BIT]
                       && dev_active[2] && win_valid[3];
         ir_irq <= ir_irq_req && dev_active[3] && win_valid[4];
         ir_dma <= ir_dma_req && ir_dma_enable && dev_active[3] && win_valid[4];
      end
   end

   gpio_pad_ctrl u_pads (
      .clk(clk),
      .resetn(resetn),
      .polarity(pol_reg),
      .buffer_type(buf_reg),
      .upper_out_data(upper_gpio_out_data),
      .upper_dir(upper_gpio_dir),
      .upper_pin_sync(pin_sync_reg),
      .trio_out_data(low_gpio_trio_data),
      .trio_drive(low_gpio_trio_drive),
      .power_event_assert(power_event_assert),
      .upper_o(upper_gpio_bank_o),
      .upper_oe(upper_gpio_bank_oe),
      .upper_in_value(upper_gpio_value),
      .trio_o(low_gpio_trio_o),
      .trio_oe(low_gpio_trio_oe),
      .power_event_o(power_event_pin_o),
      .power_event_oe(power_event_pin_oe)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_pol_write;
      @(posedge clk) disable iff (!resetn)
      cfg_wr && index_reg == 8'h38 |=> pol_reg == $past(io_wdata);
   endproperty
   a_pol_write: assert property (p_pol_write) else $error("polarity write lost");

   property p_locked_outside_config;
      @(posedge clk) disable iff (!resetn)
      state_reg == config_decode_pkg::ST_RUN |=> $stable(pol_reg) && $stable(buf_reg);
   endproperty
   a_locked_outside_config: assert property (p_locked_outside_config)
      else $error("write outside config");

   property p_strap_base;
      @(posedge clk) disable iff (!resetn)
      $rose(strap_done_reg) |-> cfg_base_reg == (strap_sync_reg[1] ? 16'h004E : 16'h002E);
   endproperty
   a_strap_base: assert property (p_strap_base)
      else $error("config port power-up base wrong");

   property p_serial_gate;
      @(posedge clk) disable iff (!resetn)
      !ser1_modem_control_reg[2] |=> !ser_irq[0];
   endproperty
   a_serial_gate: assert property (p_serial_gate) else $error("serial irq not gated");

   property p_par_irq_on;
      @(posedge clk) disable iff (!resetn)
      (par_ecr_mode == 3'h2 || par_ecr_mode == 3'h3 || par_ecr_mode == 3'h6) && par_irq_req
      && dev_active[0] && win_valid[0] |=> par_irq;
   endproperty
   a_par_irq_on: assert property (p_par_irq_on) else $error("parallel irq not passed");

   property p_par_dma;
      @(posedge clk) disable iff (!resetn)
      !parallel_dma_enable |=> !par_dma;
   endproperty
   a_par_dma: assert property (p_par_dma) else $error("parallel dma not gated");

   property p_ir_dma;
      @(posedge clk) disable iff (!resetn)
      !ir_dma_enable || !win_valid[4] |=> !ir_dma;
   endproperty
   a_ir_dma: assert property (p_ir_dma) else $error("infrared dma not gated");

   property p_rt_decode;
      @(posedge clk) disable iff (!resetn)
      io_rd && win_valid[5] && io_addr[15:4] == win_base[5][15:4] |=> dev_sel[5];
   endproperty
   a_rt_decode: assert property (p_rt_decode) else $error("runtime block not decoded");

endmodule
`default_nettype wire

/* File: bench/lpc_config_host.sv */
`default_nettype none
module lpc_config_host (
   input wire logic clk,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rack
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // host side of the config port: index at base, data at base+1
   // ----------------------------------------------------------------
   initial
   begin
      io_addr = 16'hFFFF;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'hFF;
   end
   // one-cycle write; an idle bus shows the inverse, not the last value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   // answer stands one cycle, so it is taken at the next falling edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic k);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      d = io_rdata;
      k = io_rack;
      io_rd = 1'b0;
      io_addr = ~a;
   endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, pdr, pde, iwr, ird, irq_r, ired, pe_a, pe_o, pe_oe, rk, pirq, pdma;
   logic ir_d, iri, drd, strap, mode_on;
   logic [15:0] ia, cb;
   logic [7:0] iwd, ird_d, d, pctl, modem1, godat, godir, bo, boe, gv;
   logic [5:0] dsel;
   logic [3:0] doff, act;
   logic [2:0] mode, td, tdr, to, toe;
   logic [1:0] sreq, sirq;
   int err_count = 0;
   int n_tests = 0;
   config_gpio_base_decode i_config_gpio_base_decode (.clk(clk), .resetn(resetn),
      .io_addr(ia), .io_wr(iwr), .io_rd(ird), .io_wdata(iwd), .io_rdata(ird_d), .io_rack(rk),
      .dev_sel(dsel), .dev_offset(doff), .dev_wr(), .dev_rd(drd), .config_port_strap(strap),
      .dev_active(act), .par_irq_req(1'b1), .par_dma_req(pdr), .par_control(pctl),
      .par_ecr_mode(mode), .parallel_dma_enable(pde), .ser_irq_req(sreq),
      .ser1_modem_control_reg(modem1), .ser2_modem_control_reg(8'h00), .ir_irq_req(1'b1),
      .ir_dma_req(irq_r), .ir_dma_enable(ired), .par_irq(pirq), .par_dma(pdma),
      .ser_irq(sirq), .ir_irq(iri), .ir_dma(ir_d), .upper_gpio_out_data(godat),
      .upper_gpio_dir(godir), .upper_gpio_bank_in(8'h00), .upper_gpio_bank_o(bo),
      .upper_gpio_bank_oe(boe), .upper_gpio_value(gv), .low_gpio_trio_data(td),
      .low_gpio_trio_drive(tdr), .low_gpio_trio_o(to), .low_gpio_trio_oe(toe),
      .power_event_assert(pe_a), .power_event_pin_o(pe_o), .power_event_pin_oe(pe_oe));
   lpc_config_host i_lpc_config_host (.clk(clk), .io_addr(ia), .io_wr(iwr), .io_rd(ird),
      .io_wdata(iwd), .io_rdata(ird_d), .io_rack(rk));
   // ----------------------------------------------------------------
   // checks and config port helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cw(input logic [7:0] i, input logic [7:0] v);
      i_lpc_config_host.wr(cb, i);
      i_lpc_config_host.wr(16'(cb + 16'h0001), v);
   endtask
   task automatic cr(input logic [7:0] i, input logic [7:0] e);
      logic k;
      i_lpc_config_host.wr(cb, i);
      i_lpc_config_host.rd(16'(cb + 16'h0001), d, k);
      chk({7'h0, k}, 8'h01);
      chk(d, e);
   endtask
   // device reads get no config answer, only the registered select, offset and read strobe
   task automatic dv(input logic [15:0] a, input logic [5:0] s);
      logic k;
      i_lpc_config_host.rd(a, d, k);
      chk({1'b0, k, dsel}, {2'b00, s});
      chk({3'h0, drd, doff}, {4'h1, a[3:0]});
   endtask
   // gating inputs, then compare {irq, dma, serial irq, infrared dma}
   task automatic g(input logic [3:0] a, input logic c, input logic [2:0] m,
      input logic de, input logic mc, input logic ie, input logic [3:0] e);
      act = a;
      pctl = {3'h0, c, 4'h0};
      mode = m;
      pde = de;
      modem1 = {5'h0, mc, 2'h0};
      ired = ie;
      repeat (2) @(negedge clk);
      chk({2'h0, iri, sirq[1], pirq, pdma, sirq[0], ir_d}, {2'h0, a[3], 1'b0, e});
   endtask
   task automatic results;
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (4000) @(posedge clk);
      err_count++;
      results();
   end
   initial
   begin
      {resetn, pdr, pde, irq_r, ired, pe_a, strap} = 7'b0101100;
      {pctl, modem1, godat, godir, act, mode, sreq} = {8'h00, 8'h00, 8'h0F, 8'hF0, 7'h00, 2'b01};
      {td, tdr} = 6'b001111;
      cb = 16'h002E;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      i_lpc_config_host.wr(cb, 8'h55);
      cr(8'h38, 8'h00);
      cr(8'h39, 8'h80);
      chk({6'h0, pe_o, pe_oe}, 8'h00);
      pe_a = 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h0, pe_o, pe_oe}, 8'h01);
      pe_a = 1'b0;
      $display("reset values done");
      cw(8'h38, 8'hA5);
      repeat (3) @(negedge clk);
      chk(bo, 8'hAA);
      chk(boe, 8'hF0);
      chk(gv, 8'hA5);
      cw(8'h39, 8'h7B);
      cr(8'h39, 8'h7B);
      chk({to, toe, pe_o, pe_oe}, 8'h1B);
      $display("gpio done");
      cw(8'h23, 8'hDE);
      cw(8'h24, 8'hFE);
      cw(8'h25, 8'h41);
      cw(8'h2B, 8'h5F);
      cw(8'h30, 8'h2A);
      // leave config with the polarity index loaded, then try a data write
      i_lpc_config_host.wr(cb, 8'h38);
      i_lpc_config_host.wr(cb, 8'hAA);
      i_lpc_config_host.wr(16'h002F, 8'h00);
      dv(16'h037A, 6'h01);
      dv(16'h077A, 6'h02);
      dv(16'h03FD, 6'h04);
      dv(16'h02FE, 6'h10);
      dv(16'h0104, 6'h00);
      dv(16'h02AF, 6'h20);
      i_lpc_config_host.wr(cb, 8'h55);
      cr(8'h38, 8'hA5);
      $display("decode done");
      for (int m = 0; m < 8; m++)
      begin
         mode_on = (m == 2 || m == 3 || m == 6);
         g(4'hF, 1'b0, 3'(m), m[0], 1'b1, 1'b1, {mode_on, m[0], 2'b11});
      end
      g(4'hF, 1'b1, 3'h1, 1'b0, 1'b0, 1'b0, 4'b1000);
      g(4'h0, 1'b1, 3'h2, 1'b1, 1'b1, 1'b1, 4'b0000);
      $display("gating done");
      resetn = 1'b0;
      strap = 1'b1;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      cb = 16'h004E;
      i_lpc_config_host.wr(cb, 8'h55);
      cr(8'h38, 8'h00);
      cw(8'h13, 8'h01);
      cb = 16'h014E;
      cr(8'h13, 8'h01);
      $display("second reset done");
      results();
   end
endmodule
`default_nettype wire
